// ### design/fir_dec_map.svh
/*
  Address map, field widths and timing counts of the comb5 and FIR decimator.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef FIR_DEC_MAP_SVH
`define FIR_DEC_MAP_SVH

`define COEF_BASE             10'h000
`define COEF_LAST             10'h0FF
`define DATA_BASE             10'h100
`define DATA_LAST             10'h1FF
`define ADDR_COEF_OFFSET      10'h30B
`define ADDR_TAPS_MINUS_ONE   10'h30C
`define COEF_OFFSET_RESET     8'h00
`define TAPS_MINUS_ONE_RESET  8'h00
`define COMB2_W               24
`define SAMPLE_W              18
`define COEF_W                20
`define HEADROOM_W            3
`define RESULT_W              23
`define OUT16_W               16
`define OUT_GAIN_SHIFT        7
`define COMB5_ORDER           5
`define COMB5_GROWTH          25
`define COMB5_SCALE_BASE      5
`define COMB5_MAX_SHIFT       20
`define MEM_DEPTH             256
`define CLK_RATE_KHZ          125000
`define COMB5_MAX_IN_KHZ      32500

`endif

// ### design/fir_dec_pkg.sv
/*
  Types shared by the comb5 and FIR decimator: stream carriers and FIR states.
  Assumes fir_dec_map.svh on the include path.
*/
`include "fir_dec_map.svh"

package fir_dec_pkg;

  typedef struct packed {
    logic                       chan;
    logic signed [`COMB2_W-1:0] i;
    logic signed [`COMB2_W-1:0] q;
  } comb2_sample_t;

  typedef struct packed {
    logic                        chan;
    logic signed [`RESULT_W-1:0] i;
    logic signed [`RESULT_W-1:0] q;
    logic signed [`OUT16_W-1:0]  i16;
    logic signed [`OUT16_W-1:0]  q16;
  } fir_out_t;

  typedef enum logic [0:0] {
    FIR_IDLE = 1'b0,
    FIR_RUN  = 1'b1
  } fir_state_t;

endpackage

// ### design/comb5_and_ram_fir_decimator.sv
/*
  Fifth-order comb decimator followed by a RAM coefficient decimating FIR,
  with coefficient and sample memories on the internal configuration port.
  Assumes one 125 MHz clock; mode settings come from control logic on it.
*/
`include "fir_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none

module comb5_and_ram_fir_decimator #(
  parameter int ACC_W = `COMB2_W + `COMB5_GROWTH
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // Internal configuration port
  input  wire logic                    cfg_wr,
  input  wire logic [9:0]              cfg_addr,
  input  wire logic [35:0]             cfg_wdata,
  output logic      [35:0]             cfg_rdata,
  // Mode settings
  input  wire logic                    diversity_mode,
  input  wire logic [5:0]              comb5_decimation_ratio,
  input  wire logic [4:0]              comb5_scale_shift,
  input  wire logic [5:0]              fir_decimation_ratio,
  input  wire logic [2:0]              output_scale_shift,
  // Stream from the second-order comb stage
  input  wire logic                    in_valid,
  input  wire fir_dec_pkg::comb2_sample_t in_sample,
  output logic                         in_ready,
  // Stream to the output port
  output logic                         out_valid,
  output fir_dec_pkg::fir_out_t        out_sample,
  output logic                         fir_busy
);
  import fir_dec_pkg::*;

  localparam int PROD_W = `SAMPLE_W + `COEF_W;
  localparam int FACC_W = PROD_W + `HEADROOM_W;
  localparam int MIN_GAP_I = (`CLK_RATE_KHZ + `COMB5_MAX_IN_KHZ - 1) / `COMB5_MAX_IN_KHZ;
  localparam logic [2:0] MIN_GAP = 3'(MIN_GAP_I);

  function automatic logic [8:0] wrap(input logic [9:0] a, input logic [8:0] len);
    wrap = (a >= {1'b0, len}) ? 9'(a - {1'b0, len}) : a[8:0];
  endfunction

  // Saturate to the comb2 width, then keep the top 18 bits
  function automatic logic signed [`SAMPLE_W-1:0] to_sample(input logic signed [ACC_W-1:0] v);
    logic signed [`COMB2_W-1:0] s;
    s = '0;
    if (v > ACC_W'($signed({1'b0, {(`COMB2_W-1){1'b1}}})))
      s = {1'b0, {(`COMB2_W-1){1'b1}}};
    else if (v < -ACC_W'($signed({1'b0, {(`COMB2_W-1){1'b1}}})) - ACC_W'(1))
      s = {1'b1, {(`COMB2_W-1){1'b0}}};
    else
      s = v[`COMB2_W-1:0];
    to_sample = s[`COMB2_W-1 -: `SAMPLE_W];
  endfunction

  function automatic logic signed [`OUT16_W-1:0] to_out16(input logic signed [`RESULT_W-1:0] r,
                                                          input logic [2:0] sh);
    logic signed [30:0] w;
    w = '0;
    // Unit weight at shift 0, clipping; each higher setting halves, full scale at 7
    w = ($signed({r[`RESULT_W-1], r, {`OUT_GAIN_SHIFT{1'b0}}}) >>> sh) + 31'sh40;
    if (w[30:22] != {9{w[22]}})
      to_out16 = w[30] ? 16'sh8000 : 16'sh7FFF;
    else
      to_out16 = w[22:7];
  endfunction

  // Comb5 input side, one complex sample over two cycles
  logic          phase_reg;
  logic [2:0]    gap_reg;
  comb2_sample_t hold_reg;
  wire  [2:0]    min_gap = (diversity_mode && MIN_GAP < 3'h4) ? 3'h4 : MIN_GAP;
  wire           take    = in_valid & in_ready;
  wire           active  = take | phase_reg;
  wire           sel_ch  = take ? in_sample.chan : hold_reg.chan;
  wire  signed [`COMB2_W-1:0] sel_x = take ? in_sample.i : hold_reg.q;
  wire  [1:0]    idx     = {sel_ch, phase_reg};
  assign in_ready = ~phase_reg & (gap_reg == 3'h0);

  logic signed [ACC_W-1:0] integ_reg [4][`COMB5_ORDER];
  logic signed [ACC_W-1:0] dly_reg   [4][`COMB5_ORDER];
  logic signed [ACC_W-1:0] ic [`COMB5_ORDER];
  logic signed [ACC_W-1:0] cc [`COMB5_ORDER+1];
  logic [5:0]              dcnt_reg [2];
  wire  [5:0] c5_ratio = (comb5_decimation_ratio == 6'h00) ? 6'h01 : comb5_decimation_ratio;
  wire        bypass   = (c5_ratio == 6'h01);
  wire        dump     = (dcnt_reg[sel_ch] == c5_ratio - 6'h01);
  wire  [5:0] shamt    = 6'(comb5_scale_shift) + 6'(`COMB5_SCALE_BASE);

  always_comb begin
    ic[0] = integ_reg[idx][0] + ACC_W'(sel_x);
    for (int k = 1; k < `COMB5_ORDER; k++) begin
      ic[k] = integ_reg[idx][k] + ic[k-1];
    end
    cc[0] = ic[`COMB5_ORDER-1];
    for (int k = 0; k < `COMB5_ORDER; k++) begin
      cc[k+1] = cc[k] - dly_reg[idx][k];
    end
  end

  wire signed [ACC_W-1:0] scaled = cc[`COMB5_ORDER] >>> shamt;
  wire signed [`SAMPLE_W-1:0] c5_out = bypass ? sel_x[`COMB2_W-1 -: `SAMPLE_W] : to_sample(scaled);
  logic signed [`SAMPLE_W-1:0] c5_i_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 1'b0;
      gap_reg   <= 3'h0;
      hold_reg  <= '0;
      c5_i_reg  <= '0;
      dcnt_reg  <= '{default: '0};
      integ_reg <= '{default: '{default: '0}};
      dly_reg   <= '{default: '{default: '0}};
    end else begin
      phase_reg <= take;
      if (take) begin
        hold_reg <= in_sample;
        gap_reg  <= min_gap - 3'h1;
      end else if (gap_reg != 3'h0) begin
        gap_reg <= gap_reg - 3'h1;
      end
      if (active) begin
        for (int k = 0; k < `COMB5_ORDER; k++) begin
          integ_reg[idx][k] <= ic[k];
          if (dump)
            dly_reg[idx][k] <= cc[k];
        end
        if (!phase_reg && dump)
          c5_i_reg <= c5_out;
        if (phase_reg)
          dcnt_reg[sel_ch] <= dump ? 6'h00 : dcnt_reg[sel_ch] + 6'h01;
      end
    end
  end

  // FIR memories and configuration words
  logic signed [`COEF_W-1:0]     coef_mem [`MEM_DEPTH];
  logic        [2*`SAMPLE_W-1:0] data_mem [`MEM_DEPTH];
  logic [7:0]  coef_offset_reg;
  logic [7:0]  taps_m1_reg;
  logic [8:0]  wp_reg;
  logic [5:0]  fcnt_reg;

  wire [8:0] taps    = 9'(taps_m1_reg) + 9'h001;
  wire [8:0] ntot    = diversity_mode ? 9'(taps << 1) : taps;
  wire [8:0] used    = 9'(ntot + 9'(ntot[0]));
  wire [8:0] step    = diversity_mode ? 9'h002 : 9'h001;
  wire       c5_wr   = phase_reg & dump;
  wire       last_ch = (sel_ch == diversity_mode);
  wire [5:0] f_ratio = (fir_decimation_ratio == 6'h00) ? 6'h01 : fir_decimation_ratio;
  wire       trigger = c5_wr & last_ch & (fcnt_reg == f_ratio - 6'h01);
  wire       wr_coef = cfg_wr & (cfg_addr <= `COEF_LAST);
  wire       wr_data = cfg_wr & (cfg_addr >= `DATA_BASE) & (cfg_addr <= `DATA_LAST);

  always_ff @(posedge clock) begin
    if (wr_coef)
      coef_mem[cfg_addr[7:0]] <= cfg_wdata[`COEF_W-1:0];
    if (c5_wr)
      data_mem[wp_reg[7:0]] <= {c5_i_reg, c5_out};
    else if (wr_data)
      data_mem[cfg_addr[7:0]] <= cfg_wdata;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      coef_offset_reg <= `COEF_OFFSET_RESET;
      taps_m1_reg     <= `TAPS_MINUS_ONE_RESET;
      cfg_rdata       <= '0;
      wp_reg          <= '0;
      fcnt_reg        <= '0;
    end else begin
      if (cfg_wr && cfg_addr == `ADDR_COEF_OFFSET)
        coef_offset_reg <= cfg_wdata[7:0];
      if (cfg_wr && cfg_addr == `ADDR_TAPS_MINUS_ONE)
        taps_m1_reg <= cfg_wdata[7:0];
      if (cfg_addr <= `COEF_LAST)
        cfg_rdata <= 36'($unsigned(coef_mem[cfg_addr[7:0]]));
      else if (cfg_addr <= `DATA_LAST)
        cfg_rdata <= data_mem[cfg_addr[7:0]];
      else if (cfg_addr == `ADDR_COEF_OFFSET)
        cfg_rdata <= 36'(coef_offset_reg);
      else if (cfg_addr == `ADDR_TAPS_MINUS_ONE)
        cfg_rdata <= 36'(taps_m1_reg);
      else
        cfg_rdata <= '0;
      if (c5_wr)
        wp_reg <= wrap(10'(wp_reg) + 10'h001, used);
      if (c5_wr && last_ch)
        fcnt_reg <= trigger ? 6'h00 : fcnt_reg + 6'h01;
    end
  end

  // FIR sum-of-products engine
  fir_state_t state_reg;
  logic        ch_reg;
  logic [7:0]  k_reg;
  logic [8:0]  rp_reg;
  logic [8:0]  wp_snap_reg;
  logic [7:0]  ca_reg;
  logic signed [FACC_W-1:0] acc_i_reg;
  logic signed [FACC_W-1:0] acc_q_reg;

  // Oldest sample of channel c sits taps*channels minus c behind the write pointer
  function automatic logic [8:0] oldest(input logic [8:0] wp, input logic [8:0] len,
                                        input logic [8:0] n, input logic c);
    oldest = wrap(10'(wrap(10'(wp) + 10'(len) - 10'(n), len)) + 10'(c), len);
  endfunction

  wire [2*`SAMPLE_W-1:0]        d_word = data_mem[rp_reg[7:0]];
  wire signed [`COEF_W-1:0]     coef   = coef_mem[ca_reg];
  wire signed [PROD_W-1:0]      prod_i = $signed(d_word[2*`SAMPLE_W-1:`SAMPLE_W]) * coef;
  wire signed [PROD_W-1:0]      prod_q = $signed(d_word[`SAMPLE_W-1:0]) * coef;
  wire signed [FACC_W-1:0]      sum_i  = (k_reg == 8'h00 ? '0 : acc_i_reg) + FACC_W'(prod_i);
  wire signed [FACC_W-1:0]      sum_q  = (k_reg == 8'h00 ? '0 : acc_q_reg) + FACC_W'(prod_q);
  wire signed [`RESULT_W-1:0]   res_i  = sum_i[FACC_W-1 -: `RESULT_W];
  wire signed [`RESULT_W-1:0]   res_q  = sum_q[FACC_W-1 -: `RESULT_W];
  wire                          done   = (state_reg == FIR_RUN) && (k_reg == taps_m1_reg);
  assign fir_busy = (state_reg == FIR_RUN);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= FIR_IDLE;
      ch_reg      <= 1'b0;
      k_reg       <= '0;
      rp_reg      <= '0;
      wp_snap_reg <= '0;
      ca_reg      <= '0;
      acc_i_reg   <= '0;
      acc_q_reg   <= '0;
      out_valid   <= 1'b0;
      out_sample  <= '0;
    end else begin
      out_valid <= 1'b0;
      case (state_reg)
        FIR_IDLE: begin
          if (trigger) begin
            state_reg   <= FIR_RUN;
            ch_reg      <= 1'b0;
            k_reg       <= 8'h00;
            wp_snap_reg <= wrap(10'(wp_reg) + 10'h001, used);
            rp_reg      <= oldest(wrap(10'(wp_reg) + 10'h001, used), used, ntot, 1'b0);
            ca_reg      <= coef_offset_reg;
          end
        end
        FIR_RUN: begin
          acc_i_reg <= sum_i;
          acc_q_reg <= sum_q;
          k_reg     <= k_reg + 8'h01;
          rp_reg    <= wrap(10'(rp_reg) + 10'(step), used);
          ca_reg    <= ca_reg + 8'h01;
          if (done) begin
            out_valid      <= 1'b1;
            out_sample.chan <= ch_reg;
            out_sample.i   <= res_i;
            out_sample.q   <= res_q;
            out_sample.i16 <= to_out16(res_i, output_scale_shift);
            out_sample.q16 <= to_out16(res_q, output_scale_shift);
            k_reg          <= 8'h00;
            ca_reg         <= coef_offset_reg;
            if (diversity_mode && !ch_reg) begin
              ch_reg <= 1'b1;
              rp_reg <= oldest(wp_snap_reg, used, ntot, 1'b1);
            end else begin
              state_reg <= FIR_IDLE;
            end
          end
        end
        default: state_reg <= FIR_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### test/fir_dec_monitor.sv
/*
  Port checker of the comb5 and FIR decimator.
  Assumes a bind to the top module and fir_dec_map.svh on the include path.
*/
`include "fir_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none

module fir_dec_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Configuration port
  input wire logic        cfg_wr,
  input wire logic [9:0]  cfg_addr,
  input wire logic [35:0] cfg_wdata,
  input wire logic [35:0] cfg_rdata,
  // Streams
  input wire logic        diversity_mode,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        fir_busy
);
  logic [7:0] taps_reg;
  logic [9:0] busy_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Shadow of the tap word, so run length can be judged
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      taps_reg <= 8'h00;
      busy_reg <= 10'h000;
    end else begin
      if (cfg_wr && cfg_addr == `ADDR_TAPS_MINUS_ONE)
        taps_reg <= cfg_wdata[7:0];
      busy_reg <= fir_busy ? busy_reg + 10'h001 : 10'h000;
    end
  end

  in_gap_a: assert property (in_valid && in_ready |=> !in_ready [*3] ##1 in_ready)
    else $error("input spacing wrong");
  out_pulse_a: assert property (out_valid && !diversity_mode |=> !out_valid)
    else $error("output pulse too long");
  out_busy_a: assert property ($rose(out_valid) |-> $past(fir_busy))
    else $error("output without a run");
  run_len_a: assert property ($fell(fir_busy) && !diversity_mode |-> busy_reg == {2'h0, taps_reg} + 10'h001)
    else $error("run length differs from tap word");
  taps_rd_a: assert property (cfg_wr && cfg_addr == `ADDR_TAPS_MINUS_ONE ##1 cfg_addr == `ADDR_TAPS_MINUS_ONE
    |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
    else $error("tap word readback wrong");
  offset_rd_a: assert property (cfg_wr && cfg_addr == `ADDR_COEF_OFFSET ##1 cfg_addr == `ADDR_COEF_OFFSET
    |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
    else $error("offset readback wrong");
  coef_rd_a: assert property (cfg_wr && cfg_addr < 10'h100 ##1 cfg_addr == $past(cfg_addr)
    |=> cfg_rdata[19:0] == $past(cfg_wdata[19:0], 2))
    else $error("coefficient readback wrong");
  hole_rd_a: assert property (cfg_addr inside {[10'h200:10'h2FF]} |=> cfg_rdata == 36'h0)
    else $error("reserved read not zero");
endmodule

`default_nettype wire

// ### test/comb2_source_model.sv
/*
  Model of the upstream second-order comb stage.
  Assumes the bench calls send; the clock runs free.
*/
`timescale 1ns/1ps
`default_nettype none

module comb2_source_model (
  // Clock and handshake
  input  wire logic                  clock,
  input  wire logic                  in_ready,
  // Sample stream
  output logic                       in_valid,
  output fir_dec_pkg::comb2_sample_t in_sample
);
  import fir_dec_pkg::*;
  int gap;

  initial begin
    in_valid = 1'b0;
    in_sample = '0;
    gap = 0;
  end

  // Alternates prompt and slow offers; held until taken
  task automatic send(input logic signed [23:0] i, input logic signed [23:0] q, input logic c);
    repeat (gap) @(negedge clock);
    gap = 3 - gap;
    in_valid = 1'b1;
    in_sample = '{c, i, q};
    @(posedge clock);
    while (in_ready !== 1'b1) @(posedge clock);
    @(negedge clock);
    in_valid = 1'b0;
    in_sample = comb2_sample_t'(~in_sample);
  endtask
endmodule

`default_nettype wire

// ### test/comb5_and_ram_fir_decimator_bench.sv
/*
  Self-checking bench of the comb5 and FIR decimator.
  Assumes the source model and the monitor are compiled first.
*/
`include "fir_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module comb5_and_ram_fir_decimator_bench;
  import fir_dec_pkg::*;
  logic               clock, rst_b, cfg_wr, diversity_mode, in_valid, in_ready, out_valid, fir_busy;
  logic [9:0]         cfg_addr;
  logic [35:0]        cfg_wdata, cfg_rdata;
  logic [5:0]         comb5_decimation_ratio, fir_decimation_ratio;
  logic [4:0]         comb5_scale_shift;
  logic [2:0]         output_scale_shift;
  comb2_sample_t      in_sample;
  fir_out_t           out_sample;
  fir_out_t           oq[$];
  logic signed [23:0] xi, xq, hi[$], hq[$];
  int                 mismatches, checks, seed, n, k, base;

  comb5_and_ram_fir_decimator dut (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .diversity_mode(diversity_mode),
    .comb5_decimation_ratio(comb5_decimation_ratio), .comb5_scale_shift(comb5_scale_shift),
    .fir_decimation_ratio(fir_decimation_ratio), .output_scale_shift(output_scale_shift),
    .in_valid(in_valid), .in_sample(in_sample), .in_ready(in_ready), .out_valid(out_valid),
    .out_sample(out_sample), .fir_busy(fir_busy));
  comb2_source_model src (.clock(clock), .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) if (out_valid === 1'b1) oq.push_back(out_sample);

  // Unit gain path: 18-bit history word, sign-extended to the result width
  function automatic logic signed [22:0] to_result(input logic signed [23:0] x);
    return {{5{x[23]}}, x[23:6]};
  endfunction

  // Rounded 16-bit word of a result, saturating at full scale
  function automatic logic [15:0] out16_of(input logic signed [22:0] r, input logic [2:0] s);
    int v;
    v = ((int'(r) <<< (7 - s)) + 64) >>> 7;
    return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : 16'(v);
  endfunction

  task automatic wr(input logic [9:0] a, input logic [35:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [35:0] e, input logic [35:0] m);
    @(negedge clock);
    cfg_addr = a;
    @(negedge clock);
    `CHK(cfg_rdata & m, e)
  endtask

  // Older tap at off, newer tap at off+1; memories survive reset
  task automatic setup(input logic [5:0] m, input logic [4:0] s, input logic [5:0] r, input logic d,
                       input logic [7:0] off, input logic [19:0] older, input logic [19:0] newer);
    @(negedge clock);
    rst_b = 1'b0;
    comb5_decimation_ratio = m;
    comb5_scale_shift = s;
    fir_decimation_ratio = r;
    diversity_mode = d;
    output_scale_shift = 3'($random(seed));
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    wr(`ADDR_COEF_OFFSET, {28'h0, off});
    wr(`ADDR_TAPS_MINUS_ONE, 36'h1);
    wr({2'h0, off}, {16'h0, older});
    wr({2'h0, off + 8'h01}, {16'h0, newer});
    oq.delete();
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    stop_test();
  end

  initial begin
    seed = 86025;
    {mismatches, checks} = '0;
    {rst_b, cfg_wr, cfg_addr, cfg_wdata, diversity_mode} = '0;
    {comb5_decimation_ratio, fir_decimation_ratio, comb5_scale_shift, output_scale_shift} = '0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    rd(`ADDR_COEF_OFFSET, 36'h0, 36'hFF);
    rd(`ADDR_TAPS_MINUS_ONE, 36'h0, 36'hFF);
    rd(10'h250, 36'h0, 36'hF_FFFF_FFFF);
    rd(10'h3FF, 36'h0, 36'hF_FFFF_FFFF);
    // Undefined history would show as start-up transients
    for (n = 0; n < 8; n++) wr(`DATA_BASE + 10'(n), 36'h0);
    for (n = 0; n < 4; n++) begin
      base = $random(seed);
      wr(`ADDR_TAPS_MINUS_ONE, 36'(base));
      rd(`ADDR_TAPS_MINUS_ONE, 36'(base & 255), 36'hFF);
      wr(10'(base & 255), 36'(base));
      rd(10'(base & 255), 36'(base & 20'hF_FFFF), 36'hF_FFFF);
      wr(10'h1F0 + 10'(n), {base, 4'hA});
      rd(10'h1F0 + 10'(n), {base, 4'hA}, 36'hF_FFFF_FFFF);
    end
    // Bypass with random shift; unit tap on the older, then the newer sample
    for (n = 0; n < 2; n++) begin
      base = $random(seed) & 255;
      setup(6'h1, 5'($random(seed)), 6'h1, 1'b0, 8'(base), n ? 20'h0 : 20'h4_0000, n ? 20'h4_0000 : 20'h0);
      hi.delete();
      hq.delete();
      repeat (12) begin
        xi = $random(seed);
        xq = $random(seed);
        hi.push_back(xi);
        hq.push_back(xq);
        src.send(xi, xq, 1'b0);
      end
      repeat (10) @(negedge clock);
      `CHK(oq.size(), 12)
      for (k = 1; k < 12; k++) begin
        `CHK(oq[k].i, to_result(hi[k - 1 + n]))
        `CHK(oq[k].q, to_result(hq[k - 1 + n]))
        `CHK(oq[k].i16, out16_of(to_result(hi[k - 1 + n]), output_scale_shift))
        `CHK(oq[k].q16, out16_of(to_result(hq[k - 1 + n]), output_scale_shift))
      end
    end
    // Ratio and shift pairs of unit gain, ratio 1 to 32, shift up to 20 above ratio 1 and random at ratio 1
    for (n = 0; n < 6; n++) begin
      setup(6'h1 << n, n ? 5'(5 * n - 5) : 5'($random(seed)), n ? 6'(n) : 6'd32, 1'b0, 8'h0, 20'h4_0000, 20'h0);
      xi = $random(seed);
      xq = $random(seed);
      repeat (10 * (1 << n) * (n ? n : 32)) src.send(xi, xq, 1'b0);
      repeat (10) @(negedge clock);
      `CHK(oq.size(), 10)
      `CHK(oq[$].i, to_result(xi))
      `CHK(oq[$].q, to_result(xq))
    end
    setup(6'h2, 5'h0, 6'h1, 1'b1, 8'h0, 20'h4_0000, 20'h0);
    repeat (20) begin
      src.send(xi, xq, 1'b0);
      src.send(xq, xi, 1'b1);
    end
    repeat (12) @(negedge clock);
    `CHK(oq.size(), 20)
    `CHK(oq[$ - 1].chan, 1'b0)
    `CHK(oq[$ - 1].i, to_result(xi))
    `CHK(oq[$].i, to_result(xq))
    stop_test();
  end
endmodule

bind comb5_and_ram_fir_decimator fir_dec_monitor mon (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .diversity_mode(diversity_mode),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .fir_busy(fir_busy));

`default_nettype wire
